// ===== verilog/cpubls_pkg.sv
package cpubls_pkg;

   localparam int unsigned REG_COUNT = 32;
   localparam int unsigned ADDR_W    = 16;

   // Register indices of the implied operand and the pointer pairs (low byte)
   localparam logic [4:0] IDX_R0 = 5'h00;
   localparam logic [4:0] IDX_Y  = 5'h1c;
   localparam logic [4:0] IDX_Z  = 5'h1e;

   // Cycle counts per operation
   localparam logic [1:0] CYC_FALL      = 2'h1;
   localparam logic [1:0] CYC_TAKEN     = 2'h2;
   localparam logic [1:0] CYC_LOAD_DIR  = 2'h3;
   localparam logic [1:0] CYC_LOAD_DISP = 2'h2;
   localparam logic [1:0] CYC_STORE_DIR = 2'h2;
   localparam logic [1:0] CYC_PM_READ   = 2'h3;
   localparam logic [1:0] CYC_PUSH      = 2'h1;
   localparam logic [1:0] CYC_POP       = 2'h2;
   localparam logic [1:0] CYC_NVM_EXTRA = 2'h1;

   // Values after reset, and the start of the slow region
   localparam logic [15:0] PC_RESET  = 16'h0000;
   localparam logic [15:0] SP_RESET  = 16'h3fff;
   localparam logic [15:0] NVM_BASE  = 16'h8000;

   // Program counter steps: direct forms carry a second address word
   localparam logic [15:0] PC_STEP_ONE = 16'h0001;
   localparam logic [15:0] PC_STEP_TWO = 16'h0002;

   typedef enum logic [3:0] {
      OP_NOP,
      OP_BRANCH_IF_TBIT_SET,
      OP_BRANCH_IF_TBIT_CLEAR,
      OP_BRANCH_IF_IE_SET,
      OP_BRANCH_IF_IE_CLEAR,
      OP_LOAD_DIRECT,
      OP_LOAD_DISPLACED,
      OP_STORE_DIRECT,
      OP_PROGRAM_MEMORY_READ,
      OP_PUSH,
      OP_POP
   } cpubls_op_t;

   typedef struct packed {
      cpubls_op_t  op;
      logic [4:0]  rd;
      logic [4:0]  rr;
      logic [15:0] addr;
      logic [5:0]  disp;
      logic [6:0]  offset;
      logic        ptr_z;
      logic        post_inc;
      logic        implied_r0;
   } cpubls_instr_t;

   typedef struct packed {
      logic        re;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } cpubls_ds_req_t;

   typedef struct packed {
      logic        re;
      logic [15:0] addr;
   } cpubls_pm_req_t;

endpackage

// ===== verilog/cpubls_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module cpubls_regfile #(
   parameter int unsigned DEPTH = 32
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // Byte write
   input  wire logic        wr_en,
   input  wire logic [4:0]  wr_idx,
   input  wire logic [7:0]  wr_data,
   // Pointer pair write, byte write wins on overlap
   input  wire logic        pair_wr_en,
   input  wire logic [4:0]  pair_idx,
   input  wire logic [15:0] pair_data,
   // Reads
   input  wire logic [4:0]  rd_idx_a,
   output logic      [7:0]  rd_data_a,
   input  wire logic [4:0]  rd_idx_b,
   output logic      [7:0]  rd_data_b,
   output logic      [15:0] y_ptr,
   output logic      [15:0] z_ptr
);
   logic [7:0] regs [DEPTH];

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < DEPTH; i++)
            regs[i] <= 8'h00;
      end
      else
      begin
         if (pair_wr_en)
         begin
            regs[pair_idx]        <= pair_data[7:0];
            regs[pair_idx + 5'h1] <= pair_data[15:8];
         end
         if (wr_en)
            regs[wr_idx] <= wr_data;
      end
   end

   assign rd_data_a = regs[rd_idx_a];
   assign rd_data_b = regs[rd_idx_b];
   assign y_ptr     = {regs[29], regs[28]};
   assign z_ptr     = {regs[31], regs[30]};
endmodule
`default_nettype wire

// ===== verilog/cpubls_exec.sv
`timescale 1ns/1ps
`default_nettype none
module cpubls_exec
   import cpubls_pkg::*;
#(
   parameter logic [15:0] NVM_START = cpubls_pkg::NVM_BASE,
   parameter logic [15:0] SP_INIT   = cpubls_pkg::SP_RESET
) (
   // Clock and reset
   input  wire logic                       ref_clk,
   input  wire logic                       resetn,
   // Instruction issue
   input  wire logic                       instr_valid,
   input  wire cpubls_pkg::cpubls_instr_t  instr,
   output logic                            instr_ready,
   // Status flags from the status register
   input  wire logic                       tbit,
   input  wire logic                       ienable,
   // Data space
   output cpubls_pkg::cpubls_ds_req_t      ds_req,
   input  wire logic [7:0]                 ds_rdata,
   input  wire logic                       ds_wait,
   // Program memory
   output cpubls_pkg::cpubls_pm_req_t      pm_req,
   input  wire logic [7:0]                 pm_rdata,
   // Visible state
   output logic      [15:0]                pc,
   output logic      [15:0]                sp,
   input  wire logic [4:0]                 peek_idx,
   output logic      [7:0]                 peek_data
);
   import cpubls_pkg::*;

   cpubls_instr_t cur;
   logic [1:0]    cnt;
   logic [15:0]   cur_addr;
   logic [7:0]    cur_wdata;
   logic          cur_nvm;

   logic          accept;
   logic          taken;
   logic          is_data;
   logic          nvm_hit;
   logic [1:0]    base_cyc;
   logic [1:0]    next_cnt;
   logic [15:0]   next_addr;
   logic [15:0]   next_pc;
   logic          hold;
   logic          finish;
   logic [7:0]    src_byte;
   logic [15:0]   y_ptr;
   logic [15:0]   z_ptr;
   logic          wr_en;
   logic [4:0]    wr_idx;
   logic [7:0]    wr_data;
   logic          pair_wr_en;
   logic [7:0]    peek_comb;

   assign accept = instr_valid && instr_ready;

   always_comb
   begin
      case (instr.op)
         OP_BRANCH_IF_TBIT_SET:   taken = tbit;
         OP_BRANCH_IF_TBIT_CLEAR: taken = !tbit;
         OP_BRANCH_IF_IE_SET:     taken = ienable;
         OP_BRANCH_IF_IE_CLEAR:   taken = !ienable;
         default:                 taken = 1'b0;
      endcase
   end

   // Effective address and cycle count of the incoming instruction
   always_comb
   begin
      next_addr = 16'h0000;
      is_data   = 1'b1;
      case (instr.op)
         OP_LOAD_DIRECT:
         begin
            next_addr = instr.addr;
            base_cyc  = CYC_LOAD_DIR;
         end
         OP_LOAD_DISPLACED:
         begin
            next_addr = (instr.ptr_z ? z_ptr : y_ptr) + {10'h000, instr.disp};
            base_cyc  = CYC_LOAD_DISP;
         end
         OP_STORE_DIRECT:
         begin
            next_addr = instr.addr;
            base_cyc  = CYC_STORE_DIR;
         end
         OP_PROGRAM_MEMORY_READ:
         begin
            next_addr = z_ptr;
            base_cyc  = CYC_PM_READ;
            is_data   = 1'b0;
         end
         OP_PUSH:
         begin
            next_addr = sp;
            base_cyc  = CYC_PUSH;
         end
         OP_POP:
         begin
            next_addr = sp + 16'h0001;
            base_cyc  = CYC_POP;
         end
         default:
         begin
            is_data  = 1'b0;
            base_cyc = taken ? CYC_TAKEN : CYC_FALL;
         end
      endcase
      nvm_hit  = is_data && (next_addr >= NVM_START);
      // Slow path costs one cycle up front; contention adds more via ds_wait
      next_cnt = base_cyc - 2'h1 + (nvm_hit ? CYC_NVM_EXTRA : 2'h0);
   end

   always_comb
   begin
      if (taken)
         next_pc = pc + PC_STEP_ONE + {{9{instr.offset[6]}}, instr.offset};
      else if (instr.op == OP_LOAD_DIRECT || instr.op == OP_STORE_DIRECT)
         next_pc = pc + PC_STEP_TWO;
      else
         next_pc = pc + PC_STEP_ONE;
   end

   // The access may only finish once the memory stops stalling
   assign hold   = (cnt == 2'h1) && (ds_req.re || ds_req.we) && ds_wait;
   assign finish = (cnt == 2'h1) && !hold;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt         <= 2'h0;
         instr_ready <= 1'b1;
      end
      else if (accept)
      begin
         cnt         <= next_cnt;
         instr_ready <= (next_cnt == 2'h0);
      end
      else if (finish)
      begin
         cnt         <= 2'h0;
         instr_ready <= 1'b1;
      end
      else if (cnt != 2'h0 && !hold)
         cnt <= cnt - 2'h1;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cur       <= '0;
         cur_addr  <= 16'h0000;
         cur_wdata <= 8'h00;
         cur_nvm   <= 1'b0;
      end
      else if (accept)
      begin
         cur       <= instr;
         cur_addr  <= next_addr;
         cur_wdata <= src_byte;
         cur_nvm   <= nvm_hit;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pc <= PC_RESET;
         sp <= SP_INIT;
      end
      else if (accept)
      begin
         pc <= next_pc;
         if (instr.op == OP_PUSH)
            sp <= sp - 16'h0001;
         else if (instr.op == OP_POP)
            sp <= sp + 16'h0001;
      end
   end

   // Strobes are raised only for the last cycle of an access, so a
   // multi-cycle op touches memory exactly once.
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ds_req <= '0;
         pm_req <= '0;
      end
      else if (accept && next_cnt <= 2'h1)
      begin
         ds_req.re    <= instr.op == OP_LOAD_DISPLACED || instr.op == OP_POP;
         ds_req.we    <= instr.op == OP_STORE_DIRECT || instr.op == OP_PUSH;
         ds_req.addr  <= next_addr;
         ds_req.wdata <= src_byte;
         pm_req       <= '0;
      end
      else if (!accept && cnt == 2'h2)
      begin
         ds_req.re    <= cur.op == OP_LOAD_DIRECT || cur.op == OP_LOAD_DISPLACED
                         || cur.op == OP_POP;
         ds_req.we    <= cur.op == OP_STORE_DIRECT || cur.op == OP_PUSH;
         ds_req.addr  <= cur_addr;
         ds_req.wdata <= cur_wdata;
         pm_req.re    <= cur.op == OP_PROGRAM_MEMORY_READ;
         pm_req.addr  <= cur_addr;
      end
      else if (!hold)
      begin
         ds_req <= '0;
         pm_req <= '0;
      end
   end

   // Write-back on the finishing edge; no status flag is touched here
   always_comb
   begin
      wr_en      = 1'b0;
      wr_idx     = cur.rd;
      wr_data    = ds_rdata;
      pair_wr_en = 1'b0;
      if (finish)
      begin
         case (cur.op)
            OP_LOAD_DIRECT, OP_LOAD_DISPLACED, OP_POP:
               wr_en = 1'b1;
            OP_PROGRAM_MEMORY_READ:
            begin
               wr_en      = 1'b1;
               wr_idx     = cur.implied_r0 ? IDX_R0 : cur.rd;
               wr_data    = pm_rdata;
               pair_wr_en = cur.post_inc;
            end
            default:
               wr_en = 1'b0;
         endcase
      end
   end

   cpubls_regfile #(
      .DEPTH      (REG_COUNT)
   ) u_regfile (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .wr_en      (wr_en),
      .wr_idx     (wr_idx),
      .wr_data    (wr_data),
      .pair_wr_en (pair_wr_en),
      .pair_idx   (IDX_Z),
      .pair_data  (cur_addr + 16'h0001),
      .rd_idx_a   (instr.rr),
      .rd_data_a  (src_byte),
      .rd_idx_b   (peek_idx),
      .rd_data_b  (peek_comb),
      .y_ptr      (y_ptr),
      .z_ptr      (z_ptr)
   );

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         peek_data <= 8'h00;
      else
         peek_data <= peek_comb;
   end
endmodule
`default_nettype wire

// ===== bench/cpubls_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpubls_mem_model
   import cpubls_pkg::*;
(
   // Clock and stall request
   input  wire logic                  ref_clk,
   input  wire logic                  slow,
   // Data space
   input  wire cpubls_pkg::cpubls_ds_req_t ds_req,
   output logic [7:0]                 ds_rdata,
   output logic                       ds_wait,
   // Program memory
   input  wire cpubls_pkg::cpubls_pm_req_t pm_req,
   output logic [7:0]                 pm_rdata
);
   logic [7:0] mem [0:65535];
   logic [7:0] last_ds = 8'h00;
   logic [7:0] last_pm = 8'h00;
   logic       stalled = 1'b0;
   initial for (int a = 0; a < 65536; a++) mem[a] = 8'h5a ^ a[7:0];
   // One wait state per strobe when slow, like a busy controller
   assign ds_wait  = slow && (ds_req.re || ds_req.we) && !stalled;
   // Idle bus shows the inverse of the last value so stale data never matches
   assign ds_rdata = (ds_req.re && !ds_wait) ? mem[ds_req.addr] : ~last_ds;
   assign pm_rdata = pm_req.re ? (8'ha5 ^ pm_req.addr[7:0]) : ~last_pm;
   always @(posedge ref_clk)
   begin
      stalled <= ds_wait;
      last_ds <= ds_rdata;
      last_pm <= pm_rdata;
      if (ds_req.we && !ds_wait)
      begin
         mem[ds_req.addr] <= ds_req.wdata;
      end
   end
endmodule
`default_nettype wire

// ===== bench/cpubls_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cpubls_exec_chk
   import cpubls_pkg::*;
#(
   parameter logic [15:0] NVM_START = cpubls_pkg::NVM_BASE
) (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   // Issue and flags
   input  wire logic                  instr_valid,
   input  wire cpubls_pkg::cpubls_instr_t instr,
   input  wire logic                  instr_ready,
   input  wire logic                  tbit,
   input  wire logic                  ienable,
   // Memories
   input  wire cpubls_pkg::cpubls_ds_req_t ds_req,
   input  wire logic [7:0]            ds_rdata,
   input  wire logic                  ds_wait,
   input  wire cpubls_pkg::cpubls_pm_req_t pm_req,
   input  wire logic [7:0]            pm_rdata,
   // Visible state
   input  wire logic [15:0]           pc,
   input  wire logic [15:0]           sp,
   input  wire logic [4:0]            peek_idx,
   input  wire logic [7:0]            peek_data
);
   logic take;
   logic brn;
   logic hit;
   assign take = instr_valid && instr_ready;
   assign brn  = instr.op inside {[OP_BRANCH_IF_TBIT_SET:OP_BRANCH_IF_IE_CLEAR]};
   assign hit  = (instr.op == OP_BRANCH_IF_TBIT_SET && tbit)
              || (instr.op == OP_BRANCH_IF_TBIT_CLEAR && !tbit)
              || (instr.op == OP_BRANCH_IF_IE_SET && ienable)
              || (instr.op == OP_BRANCH_IF_IE_CLEAR && !ienable);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   sequence s_take(cpubls_op_t o);
      take && instr.op == o;
   endsequence
   sequence s_idle;
      !instr_ready && !ds_req.re && !ds_req.we;
   endsequence
   property p_br_taken;
      take && hit |=> !instr_ready
         && pc == $past(pc) + 16'h1 + {{9{$past(instr.offset[6])}}, $past(instr.offset)}
         ##1 instr_ready;
   endproperty
   a_br_taken: assert property (p_br_taken) else $error("taken branch wrong");
   property p_br_fall;
      take && brn && !hit |=> instr_ready && pc == $past(pc) + 16'h1;
   endproperty
   a_br_fall: assert property (p_br_fall) else $error("fall-through wrong");
   property p_ld_dir;
      s_take(OP_LOAD_DIRECT) ##0 instr.addr < NVM_START |=> s_idle
         ##1 ds_req.re && ds_req.addr == $past(instr.addr, 2) && pc == $past(pc, 2) + 16'h2;
   endproperty
   a_ld_dir: assert property (p_ld_dir) else $error("direct load wrong");
   property p_ld_nvm;
      s_take(OP_LOAD_DIRECT) ##0 instr.addr >= NVM_START |=> s_idle [*2] ##1 ds_req.re;
   endproperty
   a_ld_nvm: assert property (p_ld_nvm) else $error("slow load lacks extra cycle");
   property p_ldd;
      s_take(OP_LOAD_DISPLACED) |=> !instr_ready ##[0:1] ds_req.re;
   endproperty
   a_ldd: assert property (p_ldd) else $error("displaced load wrong");
   property p_st_dir;
      s_take(OP_STORE_DIRECT) ##0 instr.addr < NVM_START |=> !instr_ready && ds_req.we
         && ds_req.addr == $past(instr.addr);
   endproperty
   a_st_dir: assert property (p_st_dir) else $error("direct store wrong");
   property p_pm;
      s_take(OP_PROGRAM_MEMORY_READ) |=> (s_idle and !pm_req.re) ##1 pm_req.re
         ##1 instr_ready;
   endproperty
   a_pm: assert property (p_pm) else $error("program read timing wrong");
   property p_push;
      s_take(OP_PUSH) ##0 sp < NVM_START |=> instr_ready && ds_req.we
         && ds_req.addr == $past(sp) && sp == $past(sp) - 16'h1;
   endproperty
   a_push: assert property (p_push) else $error("push wrong");
   property p_pop;
      s_take(OP_POP) ##0 sp < NVM_START - 16'h1 |=> !instr_ready && ds_req.re
         && ds_req.addr == sp && sp == $past(sp) + 16'h1;
   endproperty
   a_pop: assert property (p_pop) else $error("pop wrong");
   property p_stall;
      ds_req.re && ds_wait |=> ds_req.re && $stable(ds_req.addr) && !instr_ready;
   endproperty
   a_stall: assert property (p_stall) else $error("stall not honoured");
endmodule
bind cpubls_exec cpubls_exec_chk #(.NVM_START(NVM_START)) u_chk (.ref_clk, .resetn,
   .instr_valid, .instr, .instr_ready, .tbit, .ienable, .ds_req, .ds_rdata, .ds_wait,
   .pm_req, .pm_rdata, .pc, .sp, .peek_idx, .peek_data);
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module testbench;
   import cpubls_pkg::*;
   typedef struct packed {
      cpubls_instr_t i;
      logic          f;
      logic [15:0]   dpc;
      logic [3:0]    cyc;
   } cpubls_row_t;
   logic           ref_clk = 1'b0;
   logic           resetn;
   logic           instr_valid;
   cpubls_instr_t  instr;
   logic           instr_ready;
   logic           flag;
   cpubls_ds_req_t ds_req;
   logic [7:0]     ds_rdata;
   logic           ds_wait;
   cpubls_pm_req_t pm_req;
   logic [7:0]     pm_rdata;
   logic [15:0]    pc;
   logic [15:0]    sp;
   logic [4:0]     peek_idx;
   logic [7:0]     peek_data;
   logic [15:0]    p0;
   int             n_fail = 0;
   int             comparisons = 0;
   int             cycles = 0;
   int             n;
   cpubls_row_t    rows [15];
   cpubls_row_t    hand;
   always #2 ref_clk = ~ref_clk;
   cpubls_exec DUT (.ref_clk, .resetn, .instr_valid, .instr, .instr_ready, .tbit(flag),
      .ienable(flag), .ds_req, .ds_rdata, .ds_wait, .pm_req, .pm_rdata, .pc, .sp,
      .peek_idx, .peek_data);
   // The flag column also slows data space; branches make no strobes
   cpubls_mem_model PART (.ref_clk, .slow(flag), .ds_req, .ds_rdata, .ds_wait, .pm_req,
      .pm_rdata);
   function automatic cpubls_row_t rw(cpubls_op_t op, logic [4:0] r, logic [15:0] a,
      logic [6:0] off, logic f, logic [15:0] dpc, logic [3:0] cyc);
      rw = '{'{op, r, r, a, 6'h3f, off, 1'b1, 1'b1, 1'b0}, f, dpc, cyc};
   endfunction
   task automatic close_out;
      $display("Counts: %0d mismatches in %0d comparisons", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic issue(input cpubls_row_t r);
      n = 1;
      @(posedge ref_clk);
      instr_valid <= 1'b1;
      instr <= r.i;
      flag <= r.f;
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      #1;
      while (instr_ready !== 1'b1 && n < 9)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
   endtask
   task automatic peek(input logic [4:0] idx, input logic [7:0] exp);
      @(posedge ref_clk);
      peek_idx <= idx;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(peek_data, exp)
   endtask
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         n_fail++;
         close_out();
      end
   end
   initial
   begin
      resetn = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      flag = 1'b0;
      peek_idx = 5'h00;
      rows[0]  = rw(OP_BRANCH_IF_TBIT_SET, 5'h00, 16'h0000, 7'h05, 1'b1, 16'h0006, 4'h2);
      rows[1]  = rw(OP_BRANCH_IF_TBIT_SET, 5'h00, 16'h0000, 7'h05, 1'b0, 16'h0001, 4'h1);
      rows[2]  = rw(OP_BRANCH_IF_TBIT_CLEAR, 5'h00, 16'h0000, 7'h7d, 1'b0, 16'hfffe, 4'h2);
      rows[3]  = rw(OP_BRANCH_IF_TBIT_CLEAR, 5'h00, 16'h0000, 7'h7d, 1'b1, 16'h0001, 4'h1);
      rows[4]  = rw(OP_BRANCH_IF_IE_SET, 5'h00, 16'h0000, 7'h00, 1'b1, 16'h0001, 4'h2);
      rows[5]  = rw(OP_BRANCH_IF_IE_CLEAR, 5'h00, 16'h0000, 7'h00, 1'b1, 16'h0001, 4'h1);
      rows[6]  = rw(OP_LOAD_DIRECT, 5'h10, 16'h0123, 7'h00, 1'b0, 16'h0002, 4'h3);
      rows[7]  = rw(OP_STORE_DIRECT, 5'h10, 16'h0200, 7'h00, 1'b0, 16'h0002, 4'h2);
      rows[8]  = rw(OP_LOAD_DIRECT, 5'h14, 16'h8001, 7'h00, 1'b0, 16'h0002, 4'h4);
      rows[9]  = rw(OP_STORE_DIRECT, 5'h10, 16'h9000, 7'h00, 1'b0, 16'h0002, 4'h3);
      rows[10] = rw(OP_PUSH, 5'h10, 16'h0000, 7'h00, 1'b0, 16'h0001, 4'h1);
      rows[11] = rw(OP_POP, 5'h11, 16'h0000, 7'h00, 1'b0, 16'h0001, 4'h2);
      rows[12] = rw(OP_LOAD_DISPLACED, 5'h12, 16'h0000, 7'h00, 1'b0, 16'h0001, 4'h2);
      rows[13] = rw(OP_PROGRAM_MEMORY_READ, 5'h13, 16'h0000, 7'h00, 1'b0, 16'h0001, 4'h3);
      rows[14] = rw(OP_LOAD_DIRECT, 5'h15, 16'h0010, 7'h00, 1'b1, 16'h0002, 4'h4);
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      foreach (rows[k])
      begin
         p0 = pc;
         issue(rows[k]);
         `CHK(pc - p0, rows[k].dpc)
         `CHK(n[3:0], rows[k].cyc)
      end
      peek(5'h10, 8'h79);
      peek(5'h11, 8'h79);
      peek(5'h14, 8'h5b);
      peek(5'h12, 8'h65);
      peek(5'h13, 8'ha5);
      peek(5'h1e, 8'h01);
      // Implied R0 destination without increment: Z stays at one
      hand = rw(OP_PROGRAM_MEMORY_READ, 5'h13, 16'h0000, 7'h00, 1'b0, 16'h0001, 4'h3);
      hand.i.implied_r0 = 1'b1;
      hand.i.post_inc = 1'b0;
      issue(hand);
      `CHK(n[3:0], 4'h3)
      peek(5'h00, 8'ha4);
      peek(5'h1e, 8'h01);
      // Y pointer path; Z now differs from Y, so a wrong pick reads another byte
      hand = rw(OP_LOAD_DISPLACED, 5'h16, 16'h0000, 7'h00, 1'b0, 16'h0001, 4'h2);
      hand.i.ptr_z = 1'b0;
      issue(hand);
      `CHK(n[3:0], 4'h2)
      peek(5'h16, 8'h65);
      `CHK(PART.mem[16'h0200], 8'h79)
      `CHK(PART.mem[16'h9000], 8'h79)
      // Reset in mid-run, then a taken branch at the first legal edge
      @(posedge ref_clk);
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(sp, SP_RESET)
      `CHK(pc, PC_RESET)
      `CHK(instr_ready, 1'b1)
      @(posedge ref_clk);
      resetn <= 1'b1;
      issue(rows[0]);
      `CHK(pc, 16'h0006)
      close_out();
   end
endmodule
`default_nettype wire
